// *** src/ift_pkg.sv ***
// Constants for the ingress frame trap and security classifier.
// Assumes a 100 MHz pclk and an APB3 master with word-aligned accesses.
package ift_pkg;
   localparam int NSLOT = 22;
   // Register word indexes; the byte address is four times the index.
   localparam logic [9:0] IDX_L2DA   = 10'h006;
   localparam logic [9:0] IDX_L2GRP  = 10'h007;
   localparam logic [9:0] IDX_L3     = 10'h008;
   localparam logic [9:0] IDX_L3USR  = 10'h009;
   localparam logic [9:0] IDX_ARP    = 10'h014;
   localparam logic [9:0] IDX_ARPEN  = 10'h015;
   localparam logic [9:0] IDX_ICMP   = 10'h017;
   localparam logic [9:0] IDX_ICMPEN = 10'h018;
   localparam logic [9:0] IDX_MGLO   = 10'h021;
   localparam logic [9:0] IDX_MGHI   = 10'h022;
   localparam logic [9:0] IDX_DOT1X  = 10'h054;
   localparam logic [9:0] IDX_SID0   = 10'h056;
   localparam logic [9:0] IDX_MAC0   = 10'h05C;
   localparam logic [9:0] IDX_G0X    = 10'h0B5;
   localparam logic [9:0] IDX_LEARN  = 10'h003;
   localparam logic [9:0] IDX_CTRL   = 10'h060;
   localparam logic [9:0] IDX_IPSEN  = 10'h061;
   localparam logic [9:0] IDX_DROPS  = 10'h062;
   localparam logic [9:0] IDX_CPUS   = 10'h063;
   // Storage slots.
   localparam int S_L2DA = 0, S_L2GRP = 1, S_L3 = 2, S_L3USR = 3, S_ARP = 4;
   localparam int S_ARPEN = 5, S_ICMP = 6, S_ICMPEN = 7, S_MGLO = 8, S_MGHI = 9;
   localparam int S_DOT1X = 10, S_SID0 = 11, S_MAC0 = 15, S_G0X = 18;
   localparam int S_LEARN = 19, S_CTRL = 20, S_IPSEN = 21;
   // Control register fields.
   localparam int C_CPU_EN = 0, C_MGCAP = 1, C_SAACT = 2, C_BIND = 4;
   localparam int C_BCBLK = 10, C_IPONLY = 11, C_IPSMODE = 13, C_IPSHASH = 15;
   localparam int MG_RESTRICT = 15, ARP_BLK = 10, ARP_CAP = 7, V6_CAP = 10;
   localparam int PPP_CHK = 8, SEL_LSB = 8;
   // Reset values; the MAC value is arbitrary.
   localparam logic [47:0] OWN_MAC_RST = 48'h02AA_BB00_0001;
   localparam logic [15:0] LEARN_RST   = 16'h11FF;
   localparam logic [15:0] CFG_RST     = 16'h0000;
   // Trap codes.
   localparam logic [1:0] ACT_FWD = 2'b00, ACT_CPU = 2'b10, ACT_DROP = 2'b11;
   localparam logic [1:0] SPD_1G = 2'b10, SPD_100M = 2'b01;
   localparam logic [39:0] RSV_DA_HI = 40'h01_80C2_0000;
   localparam logic [15:0] ET_ARP = 16'h0806, ET_V6 = 16'h86DD, ET_EAPOL = 16'h888E;
   localparam logic [7:0] PR_ICMP = 8'h01, PR_TCP = 8'h06, PR_UDP = 8'h11;
   localparam logic [7:0] PR_OSPF = 8'h59, CRC8_POLY = 8'h07;
   localparam logic [2:0] IPS_ARMED = 3'b111;
   // Storm timing: a base tick, with periods counted in base ticks.
   localparam int CLK_MHZ = 100;
   localparam int BASE_US = 100;
   localparam int BASE_TICK_CYC = BASE_US * CLK_MHZ;
   localparam int T200US = 200, T1MS = 1000, T2MS = 2000, T10MS = 10000;
   localparam int T20MS = 20000, T100MS = 100000;
   localparam logic [9:0] U200US = 10'(T200US / BASE_US);
   localparam logic [9:0] U1MS   = 10'(T1MS / BASE_US);
   localparam logic [9:0] U2MS   = 10'(T2MS / BASE_US);
   localparam logic [9:0] U10MS  = 10'(T10MS / BASE_US);
   localparam logic [9:0] U20MS  = 10'(T20MS / BASE_US);
   localparam logic [9:0] U100MS = 10'(T100MS / BASE_US);
endpackage : ift_pkg

// *** src/ift_classifier.sv ***
// Ingress trap and security classifier: one parsed frame descriptor in,
// one registered forward/CPU/drop decision out, registers over APB3.
// Assumes descriptor, port speed and table answers come from pclk logic.
`timescale 1ns/100ps
`default_nettype none
module ift_classifier
   import ift_pkg::*;
#(
   parameter int NPORTS    = 10,
   parameter int IDX_W     = 8,
   parameter int TICK_CYC  = BASE_TICK_CYC
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [2*NPORTS-1:0] port_speed,
   input  wire logic                in_valid,
   output logic                     in_ready,
   input  wire logic [3:0]          in_port,
   input  wire logic [47:0]         in_da,
   input  wire logic [47:0]         in_sa,
   input  wire logic [15:0]         in_ethertype,
   input  wire logic                in_ipv4,
   input  wire logic                in_ipv6,
   input  wire logic [7:0]          in_ip_proto,
   input  wire logic                in_pppoe,
   input  wire logic [15:0]         in_pppoe_sid,
   input  wire logic [4:0]          in_mgmt_class,
   input  wire logic                in_sa_known,
   input  wire logic                in_sa_port_ok,
   input  wire logic [31:0]         in_src_ip,
   output logic      [IDX_W-1:0]    ipsec_index,
   input  wire logic [2:0]          entry_flags,
   input  wire logic [31:0]         entry_ip,
   input  wire logic [47:0]         entry_mac,
   input  wire logic [3:0]          entry_port,
   output logic                     out_valid,
   input  wire logic                out_ready,
   output logic      [3:0]          out_port,
   output logic                     out_fwd,
   output logic                     out_cpu,
   output logic                     out_drop,
   output logic                     out_strip
);
   logic [15:0] cfg [NSLOT];
   logic [15:0] drop_count;
   logic [15:0] cpu_count;
   logic [7:0]  arp_cnt  [NPORTS];
   logic [7:0]  icmp_cnt [NPORTS];
   logic [13:0] base_cnt;
   logic        base_tick;
   logic        take;
   logic        acc_wr;
   logic        acc_rd;
   logic [4:0]  slot;
   logic        slot_ok;
   logic        stat_rd;
   logic [5:0]  slot_code;

   // Address decode, shared by the write and the read path.
   function automatic logic [5:0] slot_of(input logic [11:0] a);
      logic [9:0] i;
      i = a[11:2];
      if (a[1:0] != 2'b00) return 6'h3F;
      case (i)
         IDX_L2DA:        return 6'(S_L2DA);
         IDX_L2GRP:       return 6'(S_L2GRP);
         IDX_L3:          return 6'(S_L3);
         IDX_L3USR:       return 6'(S_L3USR);
         IDX_ARP:         return 6'(S_ARP);
         IDX_ARPEN:       return 6'(S_ARPEN);
         IDX_ICMP:        return 6'(S_ICMP);
         IDX_ICMPEN:      return 6'(S_ICMPEN);
         IDX_MGLO:        return 6'(S_MGLO);
         IDX_MGHI:        return 6'(S_MGHI);
         IDX_DOT1X:       return 6'(S_DOT1X);
         IDX_SID0:        return 6'(S_SID0);
         IDX_SID0 + 10'd1: return 6'(S_SID0 + 1);
         IDX_SID0 + 10'd2: return 6'(S_SID0 + 2);
         IDX_SID0 + 10'd3: return 6'(S_SID0 + 3);
         IDX_MAC0:        return 6'(S_MAC0);
         IDX_MAC0 + 10'd1: return 6'(S_MAC0 + 1);
         IDX_MAC0 + 10'd2: return 6'(S_MAC0 + 2);
         IDX_G0X:         return 6'(S_G0X);
         IDX_LEARN:       return 6'(S_LEARN);
         IDX_CTRL:        return 6'(S_CTRL);
         IDX_IPSEN:       return 6'(S_IPSEN);
         IDX_DROPS:       return 6'h3E;
         IDX_CPUS:        return 6'h3D;
         default:         return 6'h3F;
      endcase
   endfunction : slot_of

   // Ports 1..8 sit in bits 7:0, port 9 in bit 8, port 10 in bit 12.
   function automatic logic port_bit(input logic [15:0] m, input logic [3:0] p);
      if (p < 4'd8) return m[p[2:0]];
      else if (p == 4'd8) return m[8];
      else return m[12];
   endfunction : port_bit

   function automatic logic [7:0] crc8(input logic [31:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int k = 31; k >= 0; k--) begin
         c = (c[7] ^ d[k]) ? ({c[6:0], 1'b0} ^ CRC8_POLY) : {c[6:0], 1'b0};
      end
      return c;
   endfunction : crc8

   function automatic logic [9:0] period_units(input logic [1:0] sel,
                                               input logic [1:0] spd);
      case (sel)
         2'b00: return (spd == SPD_1G) ? U200US : (spd == SPD_100M) ? U2MS : U20MS;
         2'b01: return (spd == SPD_1G) ? U1MS : (spd == SPD_100M) ? U10MS : U100MS;
         2'b10: return U10MS;
         default: return U100MS;
      endcase
   endfunction : period_units

   // APB: zero wait states, unmapped or misaligned addresses answer pslverr.
   assign pready  = 1'b1;
   assign slot_code = slot_of(paddr);
   assign slot    = slot_code[4:0];
   assign slot_ok = (slot_code < 6'(NSLOT));
   assign stat_rd = (slot_of(paddr) == 6'h3E) || (slot_of(paddr) == 6'h3D);
   assign acc_wr  = psel && penable && pwrite;
   assign acc_rd  = psel && penable && !pwrite;
   assign pslverr = psel && penable && !slot_ok && !(stat_rd && !pwrite);

   always_comb begin
      prdata = 32'h0000_0000;
      if (acc_rd && slot_ok) prdata = {16'h0000, cfg[slot]};
      else if (acc_rd && slot_of(paddr) == 6'h3E) prdata = {16'h0000, drop_count};
      else if (acc_rd && slot_of(paddr) == 6'h3D) prdata = {16'h0000, cpu_count};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NSLOT; i++) cfg[i] <= CFG_RST;
         cfg[S_MAC0]     <= OWN_MAC_RST[47:32];
         cfg[S_MAC0 + 1] <= OWN_MAC_RST[31:16];
         cfg[S_MAC0 + 2] <= OWN_MAC_RST[15:0];
         cfg[S_LEARN]    <= LEARN_RST;
      end else if (acc_wr && slot_ok) begin
         cfg[slot] <= pwdata[15:0];
      end
   end

   // Shorthand views of the configuration.
   logic [15:0] ctrl;
   logic [47:0] own_mac;
   logic [30:0] mg_mask;
   logic        cpu_en;
   assign ctrl    = cfg[S_CTRL];
   assign own_mac = {cfg[S_MAC0], cfg[S_MAC0 + 1], cfg[S_MAC0 + 2]};
   assign mg_mask = {cfg[S_MGHI][14:0], cfg[S_MGLO]};
   assign cpu_en  = ctrl[C_CPU_EN];

   // Storm timebase: one tick every TICK_CYC cycles.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) base_cnt <= 14'h0000;
      else if (base_tick) base_cnt <= 14'h0000;
      else base_cnt <= base_cnt + 14'h0001;
   end
   assign base_tick = (base_cnt == 14'(TICK_CYC - 1));

   assign in_ready = !out_valid || out_ready;
   assign take     = in_valid && in_ready;

   logic is_arp;
   logic is_icmp;
   assign is_arp  = (in_ethertype == ET_ARP);
   assign is_icmp = in_ipv4 && (in_ip_proto == PR_ICMP);

   // Each port keeps its own counters and clearing timers; a frame that
   // lands on the clearing edge is counted into the new period.
   generate
      for (genvar p = 0; p < NPORTS; p++) begin : g_storm
         logic [9:0] arp_tmr;
         logic [9:0] icmp_tmr;
         logic       arp_clr;
         logic       icmp_clr;
         logic       here;
         assign here = take && (in_port == 4'(p));
         assign arp_clr  = base_tick && (arp_tmr + 10'd1 >=
               period_units(cfg[S_ARP][SEL_LSB +: 2], port_speed[2*p +: 2]));
         assign icmp_clr = base_tick && (icmp_tmr + 10'd1 >=
               period_units(cfg[S_ICMP][SEL_LSB +: 2], port_speed[2*p +: 2]));
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               arp_tmr  <= 10'h000;
               icmp_tmr <= 10'h000;
            end else begin
               if (arp_clr) arp_tmr <= 10'h000;
               else if (base_tick) arp_tmr <= arp_tmr + 10'd1;
               if (icmp_clr) icmp_tmr <= 10'h000;
               else if (base_tick) icmp_tmr <= icmp_tmr + 10'd1;
            end
         end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               arp_cnt[p]  <= 8'h00;
               icmp_cnt[p] <= 8'h00;
            end else begin
               if (arp_clr) arp_cnt[p] <= {7'h00, here && is_arp};
               else if (here && is_arp && arp_cnt[p] != 8'hFF)
                  arp_cnt[p] <= arp_cnt[p] + 8'h01;
               if (icmp_clr) icmp_cnt[p] <= {7'h00, here && is_icmp};
               else if (here && is_icmp && icmp_cnt[p] != 8'hFF)
                  icmp_cnt[p] <= icmp_cnt[p] + 8'h01;
            end
         end
      end
   endgenerate

   // Source-IP table index.
   assign ipsec_index = ctrl[C_IPSHASH] ? IDX_W'(crc8(in_src_ip))
                                        : in_src_ip[IDX_W-1:0];

   logic       storm_drop;
   logic [7:0] p_arp;
   logic [7:0] p_icmp;
   logic       rsv_da;
   logic       own_da;
   logic       grp_da;
   logic [1:0] l2_act;
   logic [1:0] l3_act;
   logic       eapol;
   logic [1:0] dot1x;
   logic       trap;
   logic       copy;
   logic       drop;
   logic       cpu_blk;
   logic       sid_hit;
   logic       ips_drop;
   logic       next_fwd;
   logic       next_cpu;

   assign p_arp  = (in_port < 4'(NPORTS)) ? arp_cnt[in_port] : 8'h00;
   assign p_icmp = (in_port < 4'(NPORTS)) ? icmp_cnt[in_port] : 8'h00;
   assign storm_drop =
      (is_arp && port_bit(cfg[S_ARPEN], in_port) && p_arp >= cfg[S_ARP][7:0]) ||
      (is_icmp && port_bit(cfg[S_ICMPEN], in_port) &&
       p_icmp >= cfg[S_ICMP][7:0]);

   assign rsv_da = (in_da[47:8] == RSV_DA_HI);
   assign own_da = (in_da == own_mac);
   assign grp_da = in_da[40];
   assign dot1x  = cfg[S_L2DA][5:4];
   assign eapol  = (in_ethertype == ET_EAPOL);

   // Reserved group address actions, code 01 acts as forward.
   always_comb begin
      l2_act = ACT_FWD;
      if (rsv_da) begin
         case (in_da[7:0])
            8'h00: l2_act = cfg[S_L2DA][1:0];
            8'h02: l2_act = cfg[S_L2DA][3:2];
            8'h03: l2_act = cfg[S_L2DA][5:4];
            8'h0E: l2_act = cfg[S_L2DA][7:6];
            8'h04: l2_act = cfg[S_G0X][1:0];
            8'h07: l2_act = cfg[S_G0X][3:2];
            8'h08: l2_act = cfg[S_G0X][5:4];
            8'h0D: l2_act = cfg[S_G0X][7:6];
            8'h05, 8'h06, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0F:
               l2_act = cfg[S_L2DA][9:8];
            8'h10: l2_act = cfg[S_L2DA][11:10];
            8'h20, 8'h21: l2_act = cfg[S_L2DA][15:14];
            default: begin
               if (in_da[7:4] == 4'h1) l2_act = cfg[S_L2DA][13:12];
               else if (in_da[7:4] == 4'h2) l2_act = cfg[S_L2GRP][1:0];
               else if (in_da[7:4] == 4'h3) l2_act = cfg[S_L2GRP][3:2];
            end
         endcase
      end
   end

   always_comb begin
      l3_act = ACT_FWD;
      if (in_ipv4) begin
         if (in_ip_proto == PR_ICMP) l3_act = cfg[S_L3][1:0];
         else if (in_ip_proto == PR_TCP) l3_act = cfg[S_L3][3:2];
         else if (in_ip_proto == PR_UDP) l3_act = cfg[S_L3][5:4];
         else if (in_ip_proto == PR_OSPF) l3_act = cfg[S_L3][7:6];
         else if (in_ip_proto == cfg[S_L3USR][7:0]) l3_act = cfg[S_L3][9:8];
         else if (in_ip_proto == cfg[S_L3USR][15:8]) l3_act = cfg[S_L3][11:10];
         else l3_act = cfg[S_L3][13:12];
      end
   end

   always_comb begin
      sid_hit = 1'b0;
      for (int s = 0; s < 4; s++) begin
         if (cfg[S_SID0 + s] == in_pppoe_sid) sid_hit = 1'b1;
      end
   end

   // Armed entries are checked; mode 0 admits matches, mode 1 rejects them.
   always_comb begin
      logic hit;
      hit = (in_src_ip == entry_ip) && (in_sa == entry_mac) && (in_port == entry_port);
      ips_drop = 1'b0;
      if (port_bit(cfg[S_IPSEN], in_port) && entry_flags == IPS_ARMED)
         ips_drop = ctrl[C_IPSMODE] ? hit : !hit;
   end

   always_comb begin
      logic mg_cap;
      logic sa_chk;
      logic d1x_port;
      mg_cap   = own_da && ctrl[C_MGCAP];
      sa_chk   = !in_sa_known && !port_bit(cfg[S_LEARN], in_port);
      d1x_port = port_bit(cfg[S_DOT1X], in_port);
      trap = (l2_act == ACT_CPU) || (l3_act == ACT_CPU);
      drop = (l2_act == ACT_DROP) || (l3_act == ACT_DROP) || storm_drop;
      copy = is_arp && cfg[S_L2GRP][ARP_CAP];
      if (in_ethertype == ET_V6 && cfg[S_L2GRP][V6_CAP]) trap = 1'b1;
      if (mg_cap) begin
         if (cfg[S_MGHI][MG_RESTRICT] && !mg_mask[in_mgmt_class]) drop = 1'b1;
         else trap = 1'b1;
      end
      if (sa_chk) begin
         if (ctrl[C_SAACT + 1]) trap = trap;
         else if (ctrl[C_SAACT]) drop = 1'b1;
         else trap = 1'b1;
      end
      if (ctrl[C_BIND] && in_sa_known && !in_sa_port_ok) drop = 1'b1;
      if (eapol && dot1x == ACT_DROP) drop = 1'b1;
      if (d1x_port && dot1x == ACT_CPU && !is_arp) begin
         if (eapol && ((rsv_da && in_da[7:0] == 8'h03) || mg_cap)) trap = 1'b1;
         else drop = 1'b1;
      end
      if (ips_drop) drop = 1'b1;
   end

   assign cpu_blk = (cpu_en && ctrl[C_BCBLK] && grp_da) ||
                    (ctrl[C_IPONLY] && grp_da && !(in_ipv4 || in_ipv6)) ||
                    (cpu_en && cfg[S_ARP][ARP_BLK] && is_arp);

   // With the CPU port off a trap falls back to plain forwarding.
   assign next_cpu = cpu_en && (trap || copy) && !cpu_blk && !drop;
   assign next_fwd = !drop && !(trap && cpu_en);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_port  <= 4'h0;
         out_fwd   <= 1'b0;
         out_cpu   <= 1'b0;
         out_drop  <= 1'b0;
         out_strip <= 1'b0;
      end else if (in_ready) begin
         out_valid <= in_valid;
         if (in_valid) begin
            out_port  <= in_port;
            out_fwd   <= next_fwd;
            out_cpu   <= next_cpu;
            out_drop  <= !next_fwd && !next_cpu;
            out_strip <= in_pppoe && (cfg[S_L2GRP][PPP_CHK +: 2] == 2'b11) && sid_hit;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drop_count <= 16'h0000;
         cpu_count  <= 16'h0000;
      end else if (take) begin
         if (!next_fwd && !next_cpu) drop_count <= drop_count + 16'h0001;
         if (next_cpu) cpu_count <= cpu_count + 16'h0001;
      end
   end
endmodule : ift_classifier
`default_nettype wire

// *** testbench/ift_classifier_props.sv ***
// Port-level checker for the ingress trap classifier.
// Assumes it is bound to ift_classifier and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module ift_classifier_props
   import ift_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        in_valid,
   input wire logic        in_ready,
   input wire logic [3:0]  in_port,
   input wire logic        in_pppoe,
   input wire logic        out_valid,
   input wire logic        out_ready,
   input wire logic [3:0]  out_port,
   input wire logic        out_fwd,
   input wire logic        out_cpu,
   input wire logic        out_drop,
   input wire logic        out_strip
);
   logic cpu_en_q;

   // Mirrors the global CPU enable so the checker can judge traps without internals.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_en_q <= 1'b0;
      end else if (psel && penable && pwrite && paddr == {IDX_CTRL, 2'b00}) begin
         cpu_en_q <= pwdata[0];
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   apb_ready_a: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   unmapped_err_a: assert property (psel && penable && paddr == 12'hFFC
      |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   in_ready_a: assert property (in_ready == (!out_valid || out_ready))
      else $error("input ready wrong");
   answer_next_a: assert property (in_valid && in_ready |=> out_valid && out_port == $past(in_port))
      else $error("decision missing after take");
   hold_stall_a: assert property (out_valid && !out_ready |=>
      out_valid && $stable({out_port, out_fwd, out_cpu, out_drop, out_strip}))
      else $error("decision changed while stalled");
   one_action_a: assert property (out_valid |-> out_drop == !(out_fwd || out_cpu))
      else $error("drop flag inconsistent");
   cpu_off_a: assert property (in_valid && in_ready && !cpu_en_q |=> !out_cpu)
      else $error("cpu redirect while cpu port off");
   strip_pppoe_a: assert property (in_valid && in_ready && !in_pppoe |=> !out_strip)
      else $error("strip on non session frame");
endmodule : ift_classifier_props
`default_nettype wire

// *** testbench/ift_cpu_model.sv ***
// Consumer of decisions on the CPU/forwarding side.
// Assumes pclk domain; stall holds ready low, as a busy consumer would.
`timescale 1ns/100ps
`default_nettype none
module ift_cpu_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic stall,
   output logic      out_ready
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_ready <= 1'b0;
      end else begin
         out_ready <= !stall;
      end
   end
endmodule : ift_cpu_model
`default_nettype wire

// *** testbench/ift_classifier_tb.sv ***
// Self-checking bench for ift_classifier: APB setup, frames, stall.
// Assumes ift_pkg, the checker and the consumer model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module ift_classifier_tb;
   import ift_pkg::*;
   localparam logic [3:0] FW = 4'h8, CP = 4'h4, DR = 4'h2;
   localparam logic [47:0] UNI = 48'h0200_0000_0099, BPDU = 48'h0180_C200_0000;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stall = 0;
   logic in_valid = 0, in_ipv4 = 0, in_ipv6 = 0, in_pppoe = 0;
   logic in_sa_known = 1, in_sa_port_ok = 1, err;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, in_src_ip = 32'h0, prdata, rd;
   logic [3:0]  in_port = 4'h0, out_port;
   logic [47:0] in_da = 48'h0, in_sa = 48'h0;
   logic [15:0] in_ethertype = 16'h0, in_pppoe_sid = 16'h0;
   logic [7:0]  in_ip_proto = PR_ICMP, ipsec_index;
   logic [4:0]  in_mgmt_class = 5'h0;
   logic [2:0]  entry_flags = 3'h0;
   logic pready, pslverr, in_ready, out_valid, out_ready, out_fwd, out_cpu, out_drop, out_strip;
   int fail_count = 0, n_tests = 0;

   always #5 pclk = ~pclk;

   ift_classifier #(.TICK_CYC(10)) ift_classifier_inst (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .port_speed(20'h0), .in_valid,
      .in_ready, .in_port, .in_da, .in_sa, .in_ethertype, .in_ipv4, .in_ipv6, .in_ip_proto,
      .in_pppoe, .in_pppoe_sid, .in_mgmt_class, .in_sa_known, .in_sa_port_ok, .in_src_ip,
      .ipsec_index, .entry_flags, .entry_ip(32'h0), .entry_mac(48'h0),
      .entry_port(4'h0), .out_valid, .out_ready, .out_port, .out_fwd, .out_cpu, .out_drop,
      .out_strip);
   ift_cpu_model ift_cpu_model_inst (.pclk, .presetn, .stall, .out_ready);

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic frame(input logic [3:0] p, input logic [47:0] da, input logic [15:0] et,
                        input logic [3:0] exp);
      @(posedge pclk);
      in_valid <= 1'b1;
      in_port <= p;
      in_da <= da;
      in_ethertype <= et;
      in_ipv4 <= (et == 16'h0800);
      in_ipv6 <= (et == ET_V6);
      do @(posedge pclk); while (in_ready !== 1'b1);
      in_valid <= 1'b0;
      #1;
      while (!(out_valid && out_ready)) begin
         @(posedge pclk);
         #1;
      end
      chk("decision", {28'h0, out_fwd, out_cpu, out_drop, out_strip}, {28'h0, exp});
      @(posedge pclk);
   endtask : frame

   task automatic t_regs();
      apb(1'b0, IDX_CTRL, 32'h0);
      chk("ctrl reset", rd, 32'h0);
      apb(1'b0, IDX_LEARN, 32'h0);
      chk("learn mask reset", rd, 32'h0000_11FF);
      apb(1'b1, IDX_L2DA, 32'hFFFF_A5A5);
      apb(1'b0, IDX_L2DA, 32'h0);
      chk("reserved action word", rd, 32'h0000_A5A5);
      apb(1'b0, 10'h3FF, 32'h0);
      chk("unmapped error", {31'h0, err}, 32'h1);
      in_src_ip <= 32'h0000_1255;
      @(posedge pclk);
      chk("ip index", {24'h0, ipsec_index}, 32'h55);
      apb(1'b1, IDX_L2DA, 32'h0);
      $display("test regs done");
   endtask : t_regs

   task automatic t_mgmt();
      frame(4'h2, OWN_MAC_RST, 16'h0800, FW);
      apb(1'b1, IDX_CTRL, 32'h3);
      frame(4'h2, OWN_MAC_RST, 16'h0800, CP);
      apb(1'b1, IDX_MGHI, 32'h8000);
      apb(1'b1, IDX_MGLO, 32'h1);
      in_mgmt_class <= 5'h01;
      frame(4'h2, OWN_MAC_RST, 16'h0800, DR);
      apb(1'b1, IDX_MGHI, 32'h0);
      apb(1'b1, IDX_CTRL, 32'h1);
      $display("test mgmt done");
   endtask : t_mgmt

   task automatic t_l2();
      logic [3:0] exp_tab [4] = '{FW, FW, CP, DR};
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, IDX_L2DA, 32'(c));
         frame(4'h3, BPDU, 16'h0800, exp_tab[c]);
      end
      apb(1'b1, IDX_L2DA, 32'h0);
      apb(1'b1, IDX_L2GRP, 32'h0400);
      frame(4'h3, UNI, ET_V6, CP);
      apb(1'b1, IDX_L2GRP, 32'h0300);
      apb(1'b1, IDX_SID0, 32'h1234);
      in_pppoe <= 1'b1;
      in_pppoe_sid <= 16'h1234;
      frame(4'h3, UNI, 16'h0800, 4'h9);
      in_pppoe <= 1'b0;
      apb(1'b1, IDX_L3, 32'h2);
      frame(4'h3, UNI, 16'h0800, CP);
      apb(1'b1, IDX_L3, 32'h0);
      apb(1'b1, IDX_IPSEN, 32'h2);
      entry_flags <= IPS_ARMED;
      frame(4'h1, UNI, 16'h0800, DR);
      entry_flags <= 3'h0;
      $display("test l2 done");
   endtask : t_l2

   task automatic t_storm();
      apb(1'b1, IDX_ARPEN, 32'h1);
      apb(1'b1, IDX_ARP, 32'h0302);
      frame(4'h0, UNI, ET_ARP, FW);
      frame(4'h0, UNI, ET_ARP, FW);
      frame(4'h0, UNI, ET_ARP, DR);
      frame(4'h1, UNI, ET_ARP, FW);
      apb(1'b1, IDX_ARP, 32'h0202);
      repeat (2100) @(posedge pclk);
      frame(4'h0, UNI, ET_ARP, FW);
      $display("test storm done");
   endtask : t_storm

   task automatic t_stall();
      @(posedge pclk);
      stall <= 1'b1;
      fork
         frame(4'h4, UNI, 16'h0800, FW);
         begin
            repeat (4) @(posedge pclk);
            #1;
            chk("refused while stalled", {31'h0, in_ready}, 32'h0);
            @(posedge pclk);
            stall <= 1'b0;
         end
      join
      apb(1'b0, IDX_CPUS, 32'h0);
      chk("cpu count", rd, 32'h4);
      $display("test stall done");
   endtask : t_stall

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_mgmt();
      t_l2();
      t_storm();
      t_stall();
      finish_test();
   end

   // The run needs about 2250 cycles; the margin covers a slow but legal design.
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      $display("[FAIL] watchdog expired");
      finish_test();
   end
endmodule : ift_classifier_tb

bind ift_classifier ift_classifier_props ift_classifier_props_inst (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .in_valid, .in_ready,
   .in_port, .in_pppoe, .out_valid, .out_ready, .out_port, .out_fwd, .out_cpu, .out_drop,
   .out_strip);
`default_nettype wire
